// ---- src/sah_host_end.sv ----
// host end: AXI4-Lite register slave that runs conversions over the link pins
// assumes same aclk as the converter end; link inputs are resynchronised here
//
// Decided for this implementation: register access over AXI4-Lite and the register offsets.
`include "sah_cfg.svh"

module sah_host_end (
   // clock and reset
   input  wire logic        aclk,
   input  wire logic        aresetn,
   // axi4-lite write
   input  wire logic [3:0]  s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   // axi4-lite read
   input  wire logic [3:0]  s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   // pins
   sah_link_if.host         link
);

   logic [15:0]             meta_q;
   logic [15:0]             sync_q;
   logic                    sclk_prev_q;
   sah_pkg::sah_host_state_t st_q;
   logic [7:0]              cnt_q;
   logic                    hi_q;
   logic                    mode2_q;
   logic                    go_q;
   logic                    done_q;
   logic [11:0]             data_q;
   logic [15:0]             ser_sh_q;
   logic [4:0]              ser_cnt_q;
   logic [15:0]             serial_q;
   logic [3:0]              waddr_q;
   logic [31:0]             wdata_q;
   logic                    wstrb0_q;
   logic                    aw_got_q;
   logic                    w_got_q;

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         meta_q <= 16'h0000;
         sync_q <= 16'h0000;
      end
      else
      begin
         meta_q <= {link.data_bus, link.status_n, link.serial_clk, link.serial_out, link.serial_frame_n};
         sync_q <= meta_q;
      end
   end

   wire [11:0] bus_s    = sync_q[15:4];
   wire        status_s = sync_q[3];
   wire        sclk_s   = sync_q[2];
   wire        sout_s   = sync_q[1];
   wire        frame_s  = sync_q[0];
   wire        sclk_fall = sclk_prev_q & ~sclk_s;
   wire        byte_fmt = (link.fmt_sel != sah_pkg::SAH_FMT_WORD);

   // axi handshakes
   wire aw_hs    = s_axi_awvalid & s_axi_awready;
   wire w_hs     = s_axi_wvalid & s_axi_wready;
   wire ar_hs    = s_axi_arvalid & s_axi_arready;
   wire do_wr    = aw_got_q & w_got_q & ~s_axi_bvalid;
   wire bvalid_d = do_wr | (s_axi_bvalid & ~s_axi_bready);
   wire rvalid_d = ar_hs | (s_axi_rvalid & ~s_axi_rready);
   wire aw_got_d = ~do_wr & (aw_got_q | aw_hs);
   wire w_got_d  = ~do_wr & (w_got_q | w_hs);
   wire wr_ctrl  = do_wr & wstrb0_q & (waddr_q == `SAH_REG_CTRL);
   wire wr_stat  = do_wr & wstrb0_q & (waddr_q == `SAH_REG_STATUS);
   wire wr_ok    = (waddr_q == `SAH_REG_CTRL) | (waddr_q == `SAH_REG_STATUS);
   wire busy     = (st_q != sah_pkg::H_IDLE);
   wire [31:0] rd_mux = (s_axi_araddr == `SAH_REG_CTRL)   ? {28'h0, 1'b0, mode2_q, link.fmt_sel} :
                        (s_axi_araddr == `SAH_REG_STATUS) ? {29'h0, status_s, done_q, busy} :
                        (s_axi_araddr == `SAH_REG_DATA)   ? {20'h0, data_q} :
                        (s_axi_araddr == `SAH_REG_SERIAL) ? {16'h0, serial_q} : 32'h0;
   wire rd_ok    = (s_axi_araddr[1:0] == 2'h0);
   wire read_end = (st_q == sah_pkg::H_READ) & (cnt_q == 8'(`SAH_ACCESS_CYC));
   wire finish   = read_end & (~byte_fmt | hi_q);

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         s_axi_awready <= 1'b0;
         s_axi_wready  <= 1'b0;
         s_axi_bvalid  <= 1'b0;
         s_axi_bresp   <= `SAH_RESP_OKAY;
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= 32'h0;
         s_axi_rresp   <= `SAH_RESP_OKAY;
         aw_got_q      <= 1'b0;
         w_got_q       <= 1'b0;
         waddr_q       <= 4'h0;
         wdata_q       <= 32'h0;
         wstrb0_q      <= 1'b0;
      end
      else
      begin
         aw_got_q      <= aw_got_d;
         w_got_q       <= w_got_d;
         s_axi_awready <= ~aw_got_d & ~bvalid_d;
         s_axi_wready  <= ~w_got_d & ~bvalid_d;
         s_axi_bvalid  <= bvalid_d;
         s_axi_arready <= ~rvalid_d;
         s_axi_rvalid  <= rvalid_d;
         if (aw_hs)
            waddr_q <= s_axi_awaddr;
         if (w_hs)
         begin
            wdata_q  <= s_axi_wdata;
            wstrb0_q <= s_axi_wstrb[0];
         end
         if (do_wr)
            s_axi_bresp <= wr_ok ? `SAH_RESP_OKAY : `SAH_RESP_SLVERR;
         if (ar_hs)
         begin
            s_axi_rdata <= rd_mux;
            s_axi_rresp <= rd_ok ? `SAH_RESP_OKAY : `SAH_RESP_SLVERR;
         end
      end
   end

   // conversion sequencer
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         link.fmt_sel           <= sah_pkg::SAH_FMT_WORD;
         link.sample_trigger_n  <= 1'b1;
         link.cs_n              <= 1'b1;
         link.rd_n              <= 1'b1;
         link.upper_byte_select <= 1'b0;
         mode2_q                <= 1'b0;
         go_q                   <= 1'b0;
         done_q                 <= 1'b0;
         st_q                   <= sah_pkg::H_IDLE;
         cnt_q                  <= 8'h00;
         hi_q                   <= 1'b0;
         data_q                 <= 12'h000;
      end
      else
      begin
         go_q   <= wr_ctrl & wdata_q[`SAH_CTRL_GO] & ~busy;
         cnt_q  <= cnt_q + 8'h01;
         // a finishing transfer wins over a clear
         if (finish)
            done_q <= 1'b1;
         else if (wr_stat & wdata_q[`SAH_ST_DONE])
            done_q <= 1'b0;
         if (wr_ctrl & ~busy)
         begin
            link.fmt_sel <= sah_pkg::sah_fmt_t'(wdata_q[`SAH_CTRL_FMT_HI:`SAH_CTRL_FMT_LO]);
            mode2_q      <= wdata_q[`SAH_CTRL_MODE2];
         end
         case (st_q)
            sah_pkg::H_IDLE:
            begin
               hi_q <= 1'b0;
               link.upper_byte_select <= 1'b0;
               if (go_q & mode2_q)
               begin
                  link.cs_n <= 1'b0;
                  link.rd_n <= 1'b0;
                  link.sample_trigger_n <= 1'b0;
                  cnt_q     <= 8'h00;
                  st_q      <= sah_pkg::H_CONV2;
               end
               else if (go_q & ~status_s)
               begin
                  link.cs_n <= 1'b0;
                  link.rd_n <= 1'b0;
                  cnt_q     <= 8'h00;
                  st_q      <= sah_pkg::H_DUMMY;
               end
               else if (go_q)
               begin
                  link.sample_trigger_n <= 1'b0;
                  cnt_q <= 8'h00;
                  st_q  <= sah_pkg::H_TRIG;
               end
            end
            sah_pkg::H_DUMMY:
            begin
               if (cnt_q == 8'(`SAH_ACCESS_CYC))
               begin
                  link.cs_n <= 1'b1;
                  link.rd_n <= 1'b1;
                  link.sample_trigger_n <= 1'b0;
                  cnt_q <= 8'h00;
                  st_q  <= sah_pkg::H_TRIG;
               end
            end
            sah_pkg::H_TRIG:
            begin
               if (cnt_q == 8'(`SAH_TRIG_CYC - 1))
               begin
                  link.sample_trigger_n <= 1'b1;
                  st_q <= sah_pkg::H_WAIT_INT;
               end
            end
            sah_pkg::H_WAIT_INT:
            begin
               if (~status_s)
               begin
                  link.cs_n <= 1'b0;
                  link.rd_n <= 1'b0;
                  cnt_q <= 8'h00;
                  st_q  <= sah_pkg::H_READ;
               end
            end
            sah_pkg::H_CONV2:
            begin
               if (cnt_q >= 8'(`SAH_SETTLE_CYC) & status_s)
               begin
                  // raised while select is low, so it cannot start a conversion
                  link.sample_trigger_n <= 1'b1;
                  cnt_q <= 8'h00;
                  st_q  <= sah_pkg::H_READ;
               end
            end
            sah_pkg::H_READ:
            begin
               if (read_end)
               begin
                  link.cs_n <= 1'b1;
                  link.rd_n <= 1'b1;
                  cnt_q <= 8'h00;
                  if (~byte_fmt)
                     data_q <= bus_s;
                  else if (hi_q)
                     data_q[11:8] <= bus_s[3:0];
                  else
                     data_q[7:0] <= bus_s[7:0];
                  st_q <= finish ? sah_pkg::H_IDLE : sah_pkg::H_GAP;
               end
            end
            sah_pkg::H_GAP:
            begin
               if (cnt_q == 8'(`SAH_GAP_CYC))
               begin
                  hi_q <= 1'b1;
                  link.upper_byte_select <= 1'b1;
                  link.cs_n <= 1'b0;
                  link.rd_n <= 1'b0;
                  cnt_q <= 8'h00;
                  st_q  <= sah_pkg::H_READ;
               end
            end
            default:
               st_q <= sah_pkg::H_IDLE;
         endcase
      end
   end

   // serial capture on falling sclk while frame is low
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         sclk_prev_q <= 1'b1;
         ser_sh_q    <= 16'h0000;
         ser_cnt_q   <= 5'h00;
         serial_q    <= 16'h0000;
      end
      else
      begin
         sclk_prev_q <= sclk_s;
         if (frame_s)
            ser_cnt_q <= 5'h00;
         else if (sclk_fall)
         begin
            ser_sh_q  <= {ser_sh_q[14:0], sout_s};
            ser_cnt_q <= ser_cnt_q + 5'h01;
            if (ser_cnt_q == 5'(`SAH_SER_BITS - 1))
               serial_q <= {ser_sh_q[14:0], sout_s};
         end
      end
   end

endmodule

// ---- src/sah_cfg.svh ----
// offsets, field positions and timing counts for the sampling converter link
// assumes a 100 MHz aclk shared by both ends
`ifndef SAH_CFG_SVH
`define SAH_CFG_SVH

`define SAH_CLK_NS        10
`define SAH_RES_W         12
`define SAH_SER_BITS      16
`define SAH_TRIG_NS       50
`define SAH_TRIG_CYC      ((`SAH_TRIG_NS + `SAH_CLK_NS - 1) / `SAH_CLK_NS)
`define SAH_ACCESS_CYC    8
`define SAH_SETTLE_CYC    8
`define SAH_GAP_CYC       4

`define SAH_REG_CTRL      4'h0
`define SAH_REG_STATUS    4'h4
`define SAH_REG_DATA      4'h8
`define SAH_REG_SERIAL    4'hc

`define SAH_CTRL_FMT_LO   0
`define SAH_CTRL_FMT_HI   1
`define SAH_CTRL_MODE2    2
`define SAH_CTRL_GO       3
`define SAH_ST_BUSY       0
`define SAH_ST_DONE       1
`define SAH_ST_PIN        2

`define SAH_RESP_OKAY     2'h0
`define SAH_RESP_SLVERR   2'h2

`endif

// ---- src/sah_pkg.sv ----
// types shared by both ends of the sampling converter link
// assumes sah_cfg.svh for all numeric constants
package sah_pkg;

   typedef enum logic [1:0] {SAH_FMT_WORD, SAH_FMT_BYTE_GATED, SAH_FMT_BYTE_FREE} sah_fmt_t;

   typedef enum logic [1:0] {DEV_IDLE, DEV_ARM, DEV_SHIFT} sah_dev_state_t;

   typedef enum logic [2:0] {H_IDLE, H_DUMMY, H_TRIG, H_WAIT_INT, H_CONV2, H_READ, H_GAP} sah_host_state_t;

endpackage

// ---- src/sah_link_if.sv ----
// pin-level link between the converter end and the host end
// open-drain pins pull high unless a driver enables; idle parallel lines read 0
interface sah_link_if;
   // host driven
   logic                sample_trigger_n;
   logic                cs_n;
   logic                rd_n;
   logic                upper_byte_select;
   sah_pkg::sah_fmt_t   fmt_sel;
   // converter driven
   logic [11:0]         data_o;
   logic                data_lo_oe;
   logic                data_hi_oe;
   logic                status_n;
   logic                sclk_oe;
   logic                serial_out_oe;
   logic                serial_frame_oe;
   // resolved pin levels
   wire  [11:0]         data_bus;
   wire                 serial_clk;
   wire                 serial_out;
   wire                 serial_frame_n;

   assign data_bus[7:0]   = data_lo_oe ? data_o[7:0] : 8'h00;
   assign data_bus[11:8]  = data_hi_oe ? data_o[11:8] : 4'h0;
   assign serial_clk      = ~sclk_oe;
   assign serial_out      = ~serial_out_oe;
   assign serial_frame_n  = ~serial_frame_oe;

   modport dev (
      input  sample_trigger_n, cs_n, rd_n, upper_byte_select, fmt_sel,
      output data_o, data_lo_oe, data_hi_oe, status_n, sclk_oe, serial_out_oe, serial_frame_oe
   );

   modport host (
      output sample_trigger_n, cs_n, rd_n, upper_byte_select, fmt_sel,
      input  data_bus, status_n, serial_clk, serial_out, serial_frame_n
   );
endinterface

// ---- src/sah_dev_end.sv ----
// converter end: start control, status pin, parallel/byte read-out, serial stream
// assumes host pins are asynchronous; sample_value is the settled code to convert
//
// Functional notes
// - trigger rising edge starts conversion, enters hold
// - hold released when conversion completes
// - trigger ignored while chip select low
// - trigger mode: status is interrupt, low at end
// - chip select with read clears interrupt, returns result
// - host keeps trigger high during reads
// - host never ties select or read low
// - no read-out during conversion; host waits
// - interrupt low after reset; dummy read clears
// - select fall, byte-select low, trigger low starts
// - host mode: status is busy during conversion
// - word format alone, else byte plus serial
// - word read gives whole result at once
// - byte read: low eight or upper four
// - serial word: four zeros, result, msb first
// - bit changes on sclk rise, frame low
// - frame low within three clocks of start
// - serial pins are open drain
// - sclk from clock; free or gated by format
// - first byte read either byte, clears interrupt
// - host mode bytes: low first, then upper
// - serial identical in both modes
`include "sah_cfg.svh"

module sah_dev_end (
   // clock and reset
   input  wire logic                  aclk,
   input  wire logic                  aresetn,
   // converter core
   input  wire logic [`SAH_RES_W-1:0] sample_value,
   output logic                       in_hold,
   // pins
   sah_link_if.dev                    link
);

   logic [5:0]                   pins_in;
   logic [5:0]                   meta_q;
   logic [5:0]                   sync_q;
   logic [5:0]                   prev_q;
   sah_pkg::sah_dev_state_t      state_q;
   sah_pkg::sah_dev_state_t      state_d;
   logic                         phase_q;
   logic [3:0]                   cnt_q;
   logic [3:0]                   cnt_d;
   logic [`SAH_SER_BITS-1:0]     shreg_q;
   logic [`SAH_SER_BITS-1:0]     shreg_d;
   logic [`SAH_RES_W-1:0]        result_q;
   logic                         mode2_q;
   logic                         int_pend_q;
   logic                         int_pend_d;
   logic                         conv_end;

   assign pins_in = {link.sample_trigger_n, link.cs_n, link.rd_n, link.upper_byte_select, link.fmt_sel};

   // only the second stage and prev_q, its one-cycle-old copy for edges, are looked at
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         meta_q <= 6'h3c;
         sync_q <= 6'h3c;
         prev_q <= 6'h3c;
      end
      else
      begin
         meta_q <= pins_in;
         sync_q <= meta_q;
         prev_q <= sync_q;
      end
   end

   wire                    trig_s    = sync_q[5];
   wire                    cs_s      = sync_q[4];
   wire                    rd_s      = sync_q[3];
   wire                    ubs_s     = sync_q[2];
   wire sah_pkg::sah_fmt_t fmt_s     = sah_pkg::sah_fmt_t'(sync_q[1:0]);
   wire                    conv_now  = (state_q != sah_pkg::DEV_IDLE);
   wire                    conv_next = (state_d != sah_pkg::DEV_IDLE);
   wire                    trig_rise = trig_s & ~prev_q[5];
   wire                    cs_fall   = ~cs_s & prev_q[4];
   wire                    sel       = ~cs_s & ~rd_s;
   wire                    sel_prev  = ~prev_q[4] & ~prev_q[3];
   wire                    read_fall = sel & ~sel_prev & ~conv_now;
   wire                    start1    = trig_rise & cs_s & ~conv_now;
   wire                    start2    = cs_fall & ~trig_s & ~ubs_s & ~conv_now;
   wire                    start     = start1 | start2;
   wire                    ser_en    = (fmt_s != sah_pkg::SAH_FMT_WORD);
   wire                    sclk_free = (fmt_s == sah_pkg::SAH_FMT_BYTE_FREE);
   wire                    phase_d   = ~phase_q;
   wire                    rise_edge = ~phase_q;

   // sclk rises at edges where phase goes 0 to 1; shifting happens only there
   always_comb
   begin
      state_d  = state_q;
      cnt_d    = cnt_q;
      shreg_d  = shreg_q;
      conv_end = 1'b0;
      case (state_q)
         sah_pkg::DEV_IDLE:
         begin
            if (start)
               state_d = sah_pkg::DEV_ARM;
         end
         sah_pkg::DEV_ARM:
         begin
            if (rise_edge)
            begin
               state_d = sah_pkg::DEV_SHIFT;
               shreg_d = {4'h0, result_q};
               cnt_d   = 4'h0;
            end
         end
         sah_pkg::DEV_SHIFT:
         begin
            if (rise_edge)
            begin
               if (cnt_q == 4'hf)
               begin
                  state_d  = sah_pkg::DEV_IDLE;
                  conv_end = 1'b1;
               end
               else
               begin
                  shreg_d = {shreg_q[`SAH_SER_BITS-2:0], 1'b0};
                  cnt_d   = cnt_q + 4'h1;
               end
            end
         end
         default:
            state_d = sah_pkg::DEV_IDLE;
      endcase
   end

   // a new end of conversion wins over a read in the same cycle
   always_comb
   begin
      int_pend_d = int_pend_q;
      if (read_fall)
         int_pend_d = 1'b0;
      // busy-mode conversions leave no interrupt behind
      if (conv_end & ~mode2_q)
         int_pend_d = 1'b1;
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         state_q    <= sah_pkg::DEV_IDLE;
         phase_q    <= 1'b0;
         cnt_q      <= 4'h0;
         shreg_q    <= 16'h0000;
         result_q   <= 12'h000;
         mode2_q    <= 1'b0;
         int_pend_q <= 1'b1;
         in_hold    <= 1'b0;
      end
      else
      begin
         state_q    <= state_d;
         phase_q    <= phase_d;
         cnt_q      <= cnt_d;
         shreg_q    <= shreg_d;
         int_pend_q <= int_pend_d;
         if (start)
         begin
            result_q <= sample_value;
            mode2_q  <= start2;
            in_hold  <= 1'b1;
         end
         else if (conv_end)
            in_hold  <= 1'b0;
      end
   end

   // pin drivers, all registered; serial pins only ever pull low
   wire shifting_d = (state_d == sah_pkg::DEV_SHIFT);
   wire mode2_d    = start ? start2 : mode2_q;
   wire status_d   = mode2_d ? ~conv_next : ~int_pend_d;
   wire lo_oe_d    = sel & ~conv_next;
   wire hi_oe_d    = sel & ~conv_next & ~ser_en;
   wire [11:0] rd_word = ser_en ? (ubs_s ? {8'h00, result_q[11:8]} : {4'h0, result_q[7:0]})
                                : result_q;

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         link.data_o          <= 12'h000;
         link.data_lo_oe      <= 1'b0;
         link.data_hi_oe      <= 1'b0;
         link.status_n        <= 1'b1;
         link.sclk_oe         <= 1'b0;
         link.serial_out_oe   <= 1'b0;
         link.serial_frame_oe <= 1'b0;
      end
      else
      begin
         link.data_o          <= rd_word;
         link.data_lo_oe      <= lo_oe_d;
         link.data_hi_oe      <= hi_oe_d;
         link.status_n        <= status_d;
         link.sclk_oe         <= ser_en & (shifting_d | sclk_free) & ~phase_d;
         link.serial_out_oe   <= ser_en & shifting_d & ~shreg_d[`SAH_SER_BITS-1];
         link.serial_frame_oe <= ser_en & shifting_d;
      end
   end

endmodule

// ---- bench/sah_link_chk.sv ----
// pin-level assertions for the converter link, one aclk domain
// assumes it sits beside the link interface and watches the drive enables
module sah_link_chk (
   // clock and reset
   input wire logic              aclk,
   input wire logic              aresetn,
   // link pins
   input wire logic              sample_trigger_n,
   input wire logic              cs_n,
   input wire logic              upper_byte_select,
   input wire sah_pkg::sah_fmt_t fmt_sel,
   input wire logic              data_lo_oe,
   input wire logic              data_hi_oe,
   input wire logic              status_n,
   input wire logic              sclk_oe,
   input wire logic              serial_out_oe,
   input wire logic              serial_frame_oe
);
   logic [3:0] cs_idle_q;
   logic       word_w;

   assign word_w = (fmt_sel == sah_pkg::SAH_FMT_WORD);

   // cycles since select was last low; saturates so it never wraps
   always_ff @(posedge aclk)
   begin
      if (!aresetn || !cs_n)
         cs_idle_q <= 4'h0;
      else if (cs_idle_q != 4'hf)
         cs_idle_q <= cs_idle_q + 4'h1;
   end

   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);

   sequence s_lead_zeros; serial_out_oe [*6]; endsequence
   sequence s_host_start; $fell(cs_n) && !sample_trigger_n && !upper_byte_select && status_n; endsequence
   sequence s_trig_start; $rose(sample_trigger_n) && cs_n && !word_w && !serial_frame_oe; endsequence

   property p_no_read_conv; serial_frame_oe |-> !data_lo_oe && !data_hi_oe; endproperty
   a_no_read_conv: assert property (p_no_read_conv) else $error("data lanes driven in conversion");
   property p_word_quiet; word_w [*6] |-> !serial_frame_oe && !sclk_oe; endproperty
   a_word_quiet: assert property (p_word_quiet) else $error("serial pins active in word format");
   property p_hi_lanes; (!word_w) [*6] |-> !data_hi_oe; endproperty
   a_hi_lanes: assert property (p_hi_lanes) else $error("upper lanes driven in byte format");
   property p_bit_edge; serial_frame_oe && $past(serial_frame_oe) && $changed(serial_out_oe) |-> $fell(sclk_oe); endproperty
   a_bit_edge: assert property (p_bit_edge) else $error("serial bit changed off the clock rise");
   property p_lead_zeros; $rose(serial_frame_oe) |-> ##1 s_lead_zeros; endproperty
   a_lead_zeros: assert property (p_lead_zeros) else $error("leading zeros missing");
   property p_frame_start; s_trig_start |-> ##[1:6] serial_frame_oe; endproperty
   a_frame_start: assert property (p_frame_start) else $error("frame late after trigger");
   property p_host_start; s_host_start |-> ##[1:6] !status_n; endproperty
   a_host_start: assert property (p_host_start) else $error("select fall did not start");
   property p_busy_hold; $fell(status_n) && !sample_trigger_n |-> !status_n [*8]; endproperty
   a_busy_hold: assert property (p_busy_hold) else $error("busy released early");
   property p_end; $fell(serial_frame_oe) |-> ##[0:3] (status_n == !sample_trigger_n); endproperty
   a_end: assert property (p_end) else $error("status wrong at end of conversion");
   property p_int_clear; $rose(status_n) |-> cs_idle_q < 4'h6; endproperty
   a_int_clear: assert property (p_int_clear) else $error("interrupt cleared without a read");
endmodule

// ---- bench/sampling_adc_host_interface_tb.sv ----
// bench for the converter link: both ends joined, host end driven over axi4-lite
// assumes the poll bounds below cover a conversion with margin
`include "sah_cfg.svh"
`define CHK(nm, e, g) \
   begin \
      num_checks++; \
      if ((g) !== (e)) \
      begin \
         fail_count++; \
         $display("Error %s expected %h seen %h", nm, e, g); \
      end \
   end

module sampling_adc_host_interface_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic        aclk = 1'b0;
   logic        aresetn = 1'b0;
   logic [11:0] sample_value = 12'h000;
   logic        in_hold;
   logic [3:0]  awaddr = 4'h0, araddr = 4'h0, wstrb = 4'h0;
   logic [31:0] wdata = 32'h0;
   logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic        awready, wready, bvalid, arready, rvalid;
   logic [1:0]  bresp, rresp, resp;
   logic [31:0] rdata, rd_val;
   logic [11:0] vals [6] = '{12'hfff, 12'h000, 12'ha5c, 12'h5a3, 12'h801, 12'h17e};
   int          fail_count = 0;
   int          num_checks = 0;

   always #5 aclk = ~aclk;

   sah_link_if link ();
   sah_dev_end i_sah_dev_end (.aclk(aclk), .aresetn(aresetn), .sample_value(sample_value), .in_hold(in_hold),
      .link(link));
   sah_host_end i_sah_host_end (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
      .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
      .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .link(link));
   sah_link_chk i_sah_link_chk (.aclk(aclk), .aresetn(aresetn), .sample_trigger_n(link.sample_trigger_n),
      .cs_n(link.cs_n), .upper_byte_select(link.upper_byte_select), .fmt_sel(link.fmt_sel),
      .data_lo_oe(link.data_lo_oe), .data_hi_oe(link.data_hi_oe), .status_n(link.status_n),
      .sclk_oe(link.sclk_oe), .serial_out_oe(link.serial_out_oe), .serial_frame_oe(link.serial_frame_oe));

   task automatic final_report;
      $display("checks %0d mismatches %0d", num_checks, fail_count);
      if (fail_count == 0 && num_checks > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask

   task automatic guard(input int n);
      if (n >= 100)
      begin
         fail_count++;
         $display("Error wait expected answer seen timeout");
         final_report();
      end
   endtask

   // address and data offered together; each released once taken
   task automatic axi_wr(input logic [3:0] a, input logic [31:0] d, output logic [1:0] r);
      int   n;
      logic aw_ok, w_ok, b_ok;
      aw_ok = 1'b0;
      w_ok = 1'b0;
      b_ok = 1'b0;
      // one edge between transfers, so no signal is driven twice in a step
      @(posedge aclk);
      awaddr <= a;
      wdata <= d;
      wstrb <= 4'hf;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      for (n = 0; n < 100 && !b_ok; n++)
      begin
         @(posedge aclk);
         aw_ok = aw_ok | awready;
         w_ok = w_ok | wready;
         b_ok = bvalid;
         r = bresp;
         awvalid <= !aw_ok;
         wvalid <= !w_ok;
         bready <= !b_ok;
      end
      guard(n);
   endtask

   task automatic axi_rd(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
      int   n;
      logic a_ok, d_ok;
      a_ok = 1'b0;
      d_ok = 1'b0;
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      for (n = 0; n < 100 && !d_ok; n++)
      begin
         @(posedge aclk);
         a_ok = a_ok | arready;
         d_ok = rvalid;
         d = rdata;
         r = rresp;
         arvalid <= !a_ok;
         rready <= !d_ok;
      end
      guard(n);
   endtask

   // one conversion through the host sequencer, then result and pin state
   task automatic convert(input logic [1:0] f, input logic m, input logic [11:0] v);
      int n;
      sample_value <= v;
      axi_wr(`SAH_REG_CTRL, {28'h0, 1'b1, m, f}, resp);
      rd_val = 32'h0;
      for (n = 0; n < 100 && rd_val[`SAH_ST_DONE] !== 1'b1; n++)
         axi_rd(`SAH_REG_STATUS, rd_val, resp);
      guard(n);
      `CHK("busy", 1'b0, rd_val[`SAH_ST_BUSY])
      axi_rd(`SAH_REG_DATA, rd_val, resp);
      `CHK("result", {20'h0, v}, rd_val)
      if (f != sah_pkg::SAH_FMT_WORD)
      begin
         axi_rd(`SAH_REG_SERIAL, rd_val, resp);
         `CHK("serial word", {20'h0, v}, rd_val)
      end
      `CHK("hold", 1'b0, in_hold)
      axi_wr(`SAH_REG_STATUS, 32'h2, resp);
      axi_rd(`SAH_REG_STATUS, rd_val, resp);
      `CHK("status", 32'h4, rd_val)
   endtask

   initial
   begin
      repeat (16) @(posedge aclk);
      aresetn <= 1'b1;
      repeat (8) @(posedge aclk);
      axi_rd(`SAH_REG_STATUS, rd_val, resp);
      `CHK("power-up pin", 1'b0, rd_val[`SAH_ST_PIN])
      axi_wr(`SAH_REG_DATA, 32'h1, resp);
      `CHK("unmapped write", `SAH_RESP_SLVERR, resp)
      axi_rd(4'h2, rd_val, resp);
      `CHK("misaligned read", `SAH_RESP_SLVERR, resp)
      // every format in both start modes, boundary codes first
      for (int f = 0; f < 3; f++)
         for (int m = 0; m < 2; m++)
            convert(f[1:0], m[0], vals[f * 2 + m]);
      final_report();
   end
endmodule
